// ===== hw/gcb_pkg.sv
`default_nettype none
package gcb_pkg;

  // ****************************************
  // register addresses
  // ****************************************
  localparam int ADDR_W = 7;
  localparam int REG_W  = 8;
  localparam logic [6:0] A_DEVICE_IDENT_CODE     = 7'h0f;
  localparam logic [6:0] A_RATE_AXIS_POWER_CTRL  = 7'h20;
  localparam logic [6:0] A_HIGHPASS_CTRL         = 7'h21;
  localparam logic [6:0] A_PIN_EVENT_ROUTE_CTRL  = 7'h22;
  localparam logic [6:0] A_SCALE_FORMAT_CTRL     = 7'h23;
  localparam logic [6:0] A_FILTER_PATH_QUEUE_CTRL = 7'h24;
  localparam logic [6:0] A_FILTER_REFERENCE_VALUE = 7'h25;
  localparam logic [6:0] A_TEMPERATURE_OUT       = 7'h26;
  localparam logic [6:0] A_SAMPLE_STATUS         = 7'h27;
  localparam logic [6:0] A_RATE_X_LOW            = 7'h28;
  localparam logic [6:0] A_RATE_X_HIGH           = 7'h29;
  localparam logic [6:0] A_RATE_Y_LOW            = 7'h2a;
  localparam logic [6:0] A_RATE_Y_HIGH           = 7'h2b;
  localparam logic [6:0] A_RATE_Z_LOW            = 7'h2c;
  localparam logic [6:0] A_RATE_Z_HIGH           = 7'h2d;
  localparam logic [6:0] A_QUEUE_CTRL            = 7'h2e;
  localparam logic [6:0] A_QUEUE_STATUS          = 7'h2f;
  localparam logic [6:0] A_EVENT_CONFIG          = 7'h30;
  localparam logic [6:0] A_EVENT_SOURCE          = 7'h31;
  localparam logic [6:0] A_THRESHOLD_X_HIGH      = 7'h32;
  localparam logic [6:0] A_THRESHOLD_X_LOW       = 7'h33;
  localparam logic [6:0] A_THRESHOLD_Y_HIGH      = 7'h34;
  localparam logic [6:0] A_THRESHOLD_Y_LOW       = 7'h35;
  localparam logic [6:0] A_THRESHOLD_Z_HIGH      = 7'h36;
  localparam logic [6:0] A_THRESHOLD_Z_LOW       = 7'h37;
  localparam logic [6:0] A_EVENT_MIN_DURATION    = 7'h38;

  // ****************************************
  // writable slots and reset values
  // ****************************************
  localparam int NUM_RW = 15;
  localparam logic [6:0] RW_ADDR [NUM_RW] = '{
    A_RATE_AXIS_POWER_CTRL, A_HIGHPASS_CTRL, A_PIN_EVENT_ROUTE_CTRL,
    A_SCALE_FORMAT_CTRL, A_FILTER_PATH_QUEUE_CTRL, A_FILTER_REFERENCE_VALUE,
    A_QUEUE_CTRL, A_EVENT_CONFIG, A_THRESHOLD_X_HIGH, A_THRESHOLD_X_LOW,
    A_THRESHOLD_Y_HIGH, A_THRESHOLD_Y_LOW, A_THRESHOLD_Z_HIGH,
    A_THRESHOLD_Z_LOW, A_EVENT_MIN_DURATION};
  localparam int S_RATE  = 0;
  localparam int S_HP    = 1;
  localparam int S_ROUTE = 2;
  localparam int S_PATH  = 4;
  localparam logic [7:0] RST_RATE_CTRL  = 8'h07;
  localparam logic [7:0] RST_CTRL_OTHER = 8'h00;
  localparam logic [NUM_RW-1:0][7:0] RST_REGS = {{(NUM_RW-1){RST_CTRL_OTHER}}, RST_RATE_CTRL};

  // ****************************************
  // field positions
  // ****************************************
  localparam int RATE_HI = 7;
  localparam int RATE_LO = 6;
  localparam int BW_HI   = 5;
  localparam int BW_LO   = 4;
  localparam int PWR_BIT = 3;
  localparam int AXIS_HI = 2;
  localparam int AXIS_LO = 0;
  localparam int BOOTV_HI = 7;
  localparam int BOOTV_LO = 6;
  localparam int HPM_HI  = 5;
  localparam int HPM_LO  = 4;
  localparam int HIGHPASS_CUTOFF_FIELD_HI = 3;
  localparam int HIGHPASS_CUTOFF_FIELD_LO = 0;
  localparam int R_P1_EVENT = 7;
  localparam int R_P1_BOOT  = 6;
  localparam int R_P1_LOW   = 5;
  localparam int R_DRIVE_OD = 4;
  localparam int R_P2_NEW   = 3;
  localparam int R_P2_MARK  = 2;
  localparam int R_P2_OVER  = 1;
  localparam int R_P2_EMPTY = 0;
  localparam int REBOOT_BIT = 7;
  localparam logic [1:0] BOOT_LOADED_VALUE = 2'h0;
  localparam logic [1:0] HPM_RESET_ON_READ = 2'h0;
  localparam logic [3:0] HIGHPASS_CUTOFF_FIELD_LAST_CODE    = 4'h9;

  // ****************************************
  // decode tables
  // ****************************************
  localparam logic [9:0] ODR_HZ [4] = '{10'h064, 10'h0c8, 10'h190, 10'h320};
  // low-pass cut-off in tenths of a hertz, indexed by {rate, bandwidth}
  localparam logic [10:0] LP_DHZ [16] = '{
    11'h07d, 11'h0fa, 11'h0fa, 11'h0fa, 11'h07d, 11'h0fa, 11'h1f4, 11'h2bc,
    11'h0c8, 11'h0fa, 11'h1f4, 11'h44c, 11'h12c, 11'h15e, 11'h1f4, 11'h44c};
  // high-pass cut-off in hundredths of a hertz, indexed by {code, rate}
  localparam logic [12:0] HP_CHZ [40] = '{
    13'h0320, 13'h05dc, 13'h0bb8, 13'h15e0, 13'h0190, 13'h0320, 13'h05dc, 13'h0bb8,
    13'h00c8, 13'h0190, 13'h0320, 13'h05dc, 13'h0064, 13'h00c8, 13'h0190, 13'h0320,
    13'h0032, 13'h0064, 13'h00c8, 13'h0190, 13'h0014, 13'h0032, 13'h0064, 13'h00c8,
    13'h000a, 13'h0014, 13'h0032, 13'h0064, 13'h0005, 13'h000a, 13'h0014, 13'h0032,
    13'h0002, 13'h0005, 13'h000a, 13'h0014, 13'h0001, 13'h0002, 13'h0005, 13'h000a};

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {SPI_IDLE, SPI_CMD, SPI_DATA} gcb_spi_state_type;
  typedef enum logic [1:0] {PWR_DOWN, PWR_SLEEP, PWR_NORMAL} gcb_power_mode_type;
  typedef struct packed {
    logic [9:0]         sample_rate_hz;
    logic [10:0]        lowpass_dhz;
    gcb_power_mode_type power_mode;
    logic [2:0]         axis_enable;
    logic [1:0]         hp_mode;
    logic [12:0]        hp_cutoff_chz;
  } gcb_cfg_type;
  localparam gcb_cfg_type RST_CFG = '{sample_rate_hz: ODR_HZ[0], lowpass_dhz: LP_DHZ[0],
    power_mode: PWR_DOWN, axis_enable: 3'h0, hp_mode: 2'h0, hp_cutoff_chz: HP_CHZ[0]};
  typedef struct packed {
    logic [7:0]  temperature_out;
    logic [7:0]  sample_status;
    logic [15:0] rate_x;
    logic [15:0] rate_y;
    logic [15:0] rate_z;
    logic [7:0]  queue_status;
    logic [7:0]  event_source;
  } gcb_ro_data_type;
  typedef struct packed {
    logic int_event;
    logic new_sample;
    logic level_mark;
    logic overflow;
    logic drained;
  } gcb_events_type;

endpackage : gcb_pkg
`default_nettype wire

// ===== hw/gcb_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module gcb_pin_sync #(
  parameter int WIDTH = 3
) (
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic [WIDTH-1:0] raw,
  output logic      [WIDTH-1:0] level,
  output logic      [WIDTH-1:0] rise,
  output logic      [WIDTH-1:0] fall
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
  } gcb_sync_state_type;
  gcb_sync_state_type st;
  gcb_sync_state_type next_st;

  // the first stage feeds only the second; edges come from stages two and three
  always_comb begin
    next_st    = st;
    next_st.s1 = raw;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st <= '1;
    end else begin
      st <= next_st;
    end
  end

  assign level = st.s2;
  assign rise  = st.s2 & ~st.s3;
  assign fall  = ~st.s2 & st.s3;
endmodule : gcb_pin_sync
`default_nettype wire

// ===== hw/gcb_register_bank.sv
// Notes on behaviour
// - registers are bytes at seven-bit addresses
// - control locations writable, status locations read-only
// - reset: rate control 07, others 00
// - boot reload restores the factory field of high-pass control automatically
// - rate field selects 100/200/400/800 Hz
// - rate and bandwidth select low-pass cut-off
// - power bit and axes select operating mode
// - per-axis enables, default on
// - high-pass mode field decoding, reset-on-read
// - cut-off code and rate select high-pass
// - pin one carries events only when enabled
// - boot status routed to pin one
// - polarity bit inverts pin one
// - drive bit selects push-pull or open-drain
// - new sample routed to pin two
// - watermark routed to pin two
// - overrun routed to pin two
// - queue empty routed to pin two
// - multi-byte access increments from start address
// - step bit selects fixed or incrementing address
`timescale 1ns/1ps
`default_nettype none
module gcb_register_bank #(
  parameter logic [7:0] DEVICE_IDENT = 8'h5a,  // arbitrary value
  parameter int         BOOT_CYCLES  = 16
) (
  input  wire logic                     clk,
  input  wire logic                     srst,
  input  wire logic                     spi_cs_n,
  input  wire logic                     spc,
  input  wire logic                     sdi,
  input  wire gcb_pkg::gcb_ro_data_type ro_data,
  input  wire gcb_pkg::gcb_events_type  events,
  output gcb_pkg::gcb_cfg_type          cfg,
  output logic [gcb_pkg::NUM_RW-1:0][7:0] ctrl_regs,
  output logic                          boot_busy,
  output logic                          filter_reset,
  output logic                          sdo_out,
  output logic                          sdo_oe,
  output logic                          event_pin_one_out,
  output logic                          event_pin_one_oe,
  output logic                          event_pin_two_out,
  output logic                          event_pin_two_oe
);
  import gcb_pkg::*;

  localparam int BOOT_W = $clog2(BOOT_CYCLES + 1);

  typedef struct packed {
    gcb_spi_state_type         fsm;
    logic [2:0]                bitcnt;
    logic [7:0]                shin;
    logic [7:0]                shout;
    logic                      rw;
    logic                      step;
    logic [6:0]                addr;
    logic                      wr_stb;
    logic                      rd_stb;
    logic [NUM_RW-1:0][7:0]    regs;
    gcb_cfg_type               cfg;
    logic [BOOT_W-1:0]         boot_cnt;
    logic                      filter_reset;
    logic                      sdo_out;
    logic                      sdo_oe;
    logic                      p1_out;
    logic                      p1_oe;
    logic                      p2_out;
    logic                      p2_oe;
  } gcb_bank_state_type;

  // power-up runs a boot reload, so the counter starts loaded
  localparam gcb_bank_state_type RST_ST = '{fsm: SPI_IDLE, bitcnt: 3'h0, shin: 8'h00,
    shout: 8'h00, rw: 1'b0, step: 1'b0, addr: 7'h00, wr_stb: 1'b0, rd_stb: 1'b0,
    regs: RST_REGS, cfg: RST_CFG, boot_cnt: BOOT_W'(BOOT_CYCLES), filter_reset: 1'b0,
    sdo_out: 1'b0, sdo_oe: 1'b0, p1_out: 1'b0, p1_oe: 1'b1, p2_out: 1'b0, p2_oe: 1'b1};

  gcb_bank_state_type st;
  gcb_bank_state_type next_st;

  // ****************************************
  // serial pin synchronisers
  // ****************************************
  logic [2:0] pin_level;
  logic [2:0] pin_rise;
  logic [2:0] pin_fall;

  gcb_pin_sync #(
    .WIDTH (3)
  ) u_sync (
    .clk   (clk),
    .srst  (srst),
    .raw   ({spi_cs_n, spc, sdi}),
    .level (pin_level),
    .rise  (pin_rise),
    .fall  (pin_fall)
  );

  logic cs_n_s;
  logic sdi_s;
  logic spc_rise;
  logic spc_fall;
  assign cs_n_s   = pin_level[2];
  assign sdi_s    = pin_level[0];
  assign spc_rise = pin_rise[1];
  assign spc_fall = pin_fall[1];

  // ****************************************
  // read path
  // ****************************************
  function automatic logic [7:0] rd_byte(input logic [6:0] a,
                                         input logic [NUM_RW-1:0][7:0] r,
                                         input gcb_ro_data_type d);
    logic [7:0] v;
    v = 8'h00;
    for (int i = 0; i < NUM_RW; i++) begin
      if (a == RW_ADDR[i]) begin
        v = r[i];
      end
    end
    case (a)
      A_DEVICE_IDENT_CODE: v = DEVICE_IDENT;
      A_TEMPERATURE_OUT:   v = d.temperature_out;
      A_SAMPLE_STATUS:     v = d.sample_status;
      A_RATE_X_LOW:        v = d.rate_x[7:0];
      A_RATE_X_HIGH:       v = d.rate_x[15:8];
      A_RATE_Y_LOW:        v = d.rate_y[7:0];
      A_RATE_Y_HIGH:       v = d.rate_y[15:8];
      A_RATE_Z_LOW:        v = d.rate_z[7:0];
      A_RATE_Z_HIGH:       v = d.rate_z[15:8];
      A_QUEUE_STATUS:      v = d.queue_status;
      A_EVENT_SOURCE:      v = d.event_source;
      default: ;
    endcase
    return v;
  endfunction : rd_byte

  // ****************************************
  // configuration decode
  // ****************************************
  function automatic gcb_cfg_type decode_cfg(input logic [7:0] rate_reg,
                                             input logic [7:0] hp_reg,
                                             input gcb_cfg_type prev);
    gcb_cfg_type c;
    logic [1:0]  dr;
    logic [3:0]  code;
    c    = prev;
    dr   = rate_reg[RATE_HI:RATE_LO];
    code = hp_reg[HIGHPASS_CUTOFF_FIELD_HI:HIGHPASS_CUTOFF_FIELD_LO];
    c.sample_rate_hz = ODR_HZ[dr];
    c.lowpass_dhz    = LP_DHZ[{dr, rate_reg[BW_HI:BW_LO]}];
    if (!rate_reg[PWR_BIT]) begin
      c.power_mode = PWR_DOWN;
    end else if (rate_reg[AXIS_HI:AXIS_LO] == 3'h0) begin
      c.power_mode = PWR_SLEEP;
    end else begin
      c.power_mode = PWR_NORMAL;
    end
    c.axis_enable = rate_reg[PWR_BIT] ? rate_reg[AXIS_HI:AXIS_LO] : 3'h0;
    c.hp_mode = hp_reg[HPM_HI:HPM_LO];
    // undefined codes keep the last valid cut-off rather than guess one
    if (code <= HIGHPASS_CUTOFF_FIELD_LAST_CODE) begin
      c.hp_cutoff_chz = HP_CHZ[{code, dr}];
    end
    return c;
  endfunction : decode_cfg

  // ****************************************
  // next state
  // ****************************************
  logic [7:0] wbyte;
  logic       p1_level;
  logic       p1_value;
  logic       p2_value;
  logic       drive_od;

  always_comb begin
    next_st              = st;
    next_st.wr_stb       = 1'b0;
    next_st.rd_stb       = 1'b0;
    next_st.filter_reset = 1'b0;
    wbyte                = {st.shin[6:0], sdi_s};

    // serial frame: command byte, then data bytes of eight clocks
    case (st.fsm)
      SPI_IDLE: begin
        next_st.bitcnt = 3'h0;
        next_st.sdo_oe = 1'b0;
        if (!cs_n_s) begin
          next_st.fsm = SPI_CMD;
        end
      end
      SPI_CMD: begin
        if (spc_rise) begin
          next_st.shin   = wbyte;
          next_st.bitcnt = 3'(st.bitcnt + 3'h1);
          if (st.bitcnt == 3'h7) begin
            next_st.rw     = wbyte[7];
            next_st.step   = wbyte[6];
            next_st.addr   = {1'b0, wbyte[5:0]};
            next_st.rd_stb = wbyte[7];
            next_st.fsm    = SPI_DATA;
          end
        end
      end
      SPI_DATA: begin
        if (spc_rise) begin
          next_st.shin   = wbyte;
          next_st.bitcnt = 3'(st.bitcnt + 3'h1);
          if (st.bitcnt == 3'h7) begin
            if (st.rw) begin
              next_st.rd_stb = 1'b1;
              if (st.step) begin
                next_st.addr = 7'(st.addr + 7'h01);
              end
            end else begin
              next_st.wr_stb = 1'b1;
            end
          end
        end
        if (spc_fall && st.rw) begin
          next_st.sdo_out = st.shout[7];
          next_st.shout   = {st.shout[6:0], 1'b0};
          next_st.sdo_oe  = 1'b1;
        end
      end
      default: begin
        next_st.fsm = SPI_IDLE;
      end
    endcase
    if (cs_n_s) begin
      next_st.fsm    = SPI_IDLE;
      next_st.sdo_oe = 1'b0;
    end

    // register access one cycle after the byte completes
    if (st.rd_stb) begin
      next_st.shout = rd_byte(st.addr, st.regs, ro_data);
      if (st.addr == A_FILTER_REFERENCE_VALUE &&
          st.regs[S_HP][HPM_HI:HPM_LO] == HPM_RESET_ON_READ) begin
        next_st.filter_reset = 1'b1;
      end
    end
    if (st.wr_stb) begin
      // read-only and unmapped locations drop the write
      for (int i = 0; i < NUM_RW; i++) begin
        if (st.addr == RW_ADDR[i]) begin
          next_st.regs[i] = st.shin;
        end
      end
      if (st.step) begin
        next_st.addr = 7'(st.addr + 7'h01);
      end
      if (st.addr == A_FILTER_PATH_QUEUE_CTRL && st.shin[REBOOT_BIT]) begin
        next_st.boot_cnt = BOOT_W'(BOOT_CYCLES);
      end
    end

    // boot reload: factory field restored, reboot request self-clears
    if (st.boot_cnt != '0) begin
      next_st.boot_cnt = BOOT_W'(st.boot_cnt - 1'b1);
      next_st.regs[S_HP][BOOTV_HI:BOOTV_LO] = BOOT_LOADED_VALUE;
      if (st.boot_cnt == BOOT_W'(1)) begin
        next_st.regs[S_PATH][REBOOT_BIT] = 1'b0;
      end
    end

    next_st.cfg = decode_cfg(next_st.regs[S_RATE], next_st.regs[S_HP], st.cfg);

    // ****************************************
    // event pins
    // ****************************************
    p1_level = (st.regs[S_ROUTE][R_P1_EVENT] & events.int_event) |
               (st.regs[S_ROUTE][R_P1_BOOT] & (st.boot_cnt != '0));
    p1_value = p1_level ^ st.regs[S_ROUTE][R_P1_LOW];
    p2_value = (st.regs[S_ROUTE][R_P2_NEW] & events.new_sample) |
               (st.regs[S_ROUTE][R_P2_MARK] & events.level_mark) |
               (st.regs[S_ROUTE][R_P2_OVER] & events.overflow) |
               (st.regs[S_ROUTE][R_P2_EMPTY] & events.drained);
    drive_od = st.regs[S_ROUTE][R_DRIVE_OD];
    // open-drain only pulls low; a high level is left to the pull-up
    next_st.p1_out = drive_od ? 1'b0 : p1_value;
    next_st.p1_oe  = drive_od ? ~p1_value : 1'b1;
    next_st.p2_out = drive_od ? 1'b0 : p2_value;
    next_st.p2_oe  = drive_od ? ~p2_value : 1'b1;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st <= RST_ST;
    end else begin
      st <= next_st;
    end
  end

  assign cfg               = st.cfg;
  assign ctrl_regs         = st.regs;
  assign boot_busy         = (st.boot_cnt != '0);
  assign filter_reset      = st.filter_reset;
  assign sdo_out           = st.sdo_out;
  assign sdo_oe            = st.sdo_oe;
  assign event_pin_one_out = st.p1_out;
  assign event_pin_one_oe  = st.p1_oe;
  assign event_pin_two_out = st.p2_out;
  assign event_pin_two_oe  = st.p2_oe;

  // ****************************************
  // assertions
  // ****************************************
  sequence s_write_done;
    st.wr_stb && st.addr == A_RATE_AXIS_POWER_CTRL;
  endsequence
  sequence s_ro_write;
    st.wr_stb && st.addr == A_TEMPERATURE_OUT;
  endsequence

  property p_reset_values;
    @(posedge clk) $past(srst) |-> st.regs[S_RATE] == RST_RATE_CTRL && st.regs[S_ROUTE] == RST_CTRL_OTHER;
  endproperty
  a_reset_values: assert property (p_reset_values) else $error("reset values wrong");

  property p_write_lands;
    @(posedge clk) disable iff (srst) s_write_done |=> st.regs[S_RATE] == $past(st.shin);
  endproperty
  a_write_lands: assert property (p_write_lands) else $error("write not stored");

  property p_ro_ignored;
    @(posedge clk) disable iff (srst) s_ro_write |=> st.regs == $past(st.regs) || $past(st.boot_cnt) != '0;
  endproperty
  a_ro_ignored: assert property (p_ro_ignored) else $error("read-only location written");

  property p_rate;
    @(posedge clk) disable iff (srst) cfg.sample_rate_hz == ODR_HZ[st.regs[S_RATE][RATE_HI:RATE_LO]];
  endproperty
  a_rate: assert property (p_rate) else $error("sample rate mismatch");

  property p_sleep;
    @(posedge clk) disable iff (srst)
      st.regs[S_RATE][PWR_BIT] && st.regs[S_RATE][AXIS_HI:AXIS_LO] == 3'h0 |-> cfg.power_mode == PWR_SLEEP && cfg.axis_enable == 3'h0;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep mode wrong");

  property p_cut_hold;
    @(posedge clk) disable iff (srst)
      st.regs[S_HP][HIGHPASS_CUTOFF_FIELD_HI:HIGHPASS_CUTOFF_FIELD_LO] > HIGHPASS_CUTOFF_FIELD_LAST_CODE |-> cfg.hp_cutoff_chz == $past(cfg.hp_cutoff_chz);
  endproperty
  a_cut_hold: assert property (p_cut_hold) else $error("undefined code changed cut-off");

  property p_step;
    @(posedge clk) disable iff (srst) st.wr_stb && st.step |=> st.addr == 7'($past(st.addr) + 7'h01);
  endproperty
  a_step: assert property (p_step) else $error("address did not step");

  property p_pin1_event;
    @(posedge clk) disable iff (srst)
      events.int_event && st.regs[S_ROUTE][R_P1_EVENT] && !st.regs[S_ROUTE][R_P1_LOW] && !drive_od |=> event_pin_one_out;
  endproperty
  a_pin1_event: assert property (p_pin1_event) else $error("pin one missed event");

  property p_pin1_quiet;
    @(posedge clk) disable iff (srst)
      st.regs[S_ROUTE][R_P1_EVENT:R_P1_LOW] == 3'h1 && !drive_od |=> event_pin_one_out;
  endproperty
  a_pin1_quiet: assert property (p_pin1_quiet) else $error("pin one idle level wrong");

  property p_od;
    @(posedge clk) disable iff (srst) drive_od |=> !event_pin_one_out && !event_pin_two_out;
  endproperty
  a_od: assert property (p_od) else $error("open-drain pin driven high");

  property p_pin2;
    @(posedge clk) disable iff (srst)
      events.overflow && st.regs[S_ROUTE][R_P2_OVER] && !drive_od |=> event_pin_two_out && event_pin_two_oe;
  endproperty
  a_pin2: assert property (p_pin2) else $error("pin two missed overrun");

  property p_filter_reset;
    @(posedge clk) disable iff (srst)
      st.rd_stb && st.addr == A_FILTER_REFERENCE_VALUE && st.regs[S_HP][HPM_HI:HPM_LO] != HPM_RESET_ON_READ |=> !filter_reset;
  endproperty
  a_filter_reset: assert property (p_filter_reset) else $error("filter reset in wrong mode");

endmodule : gcb_register_bank
`default_nettype wire

// ===== verif/gcb_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// serial host, mode 3, bit time 8 clk
// ****************************************
module gcb_host_model (
  input  wire logic clk,
  input  wire logic sdo,
  output logic      cs_n,
  output logic      spc,
  output logic      sdi
);
  initial {cs_n, spc, sdi} = 3'b110;
  task automatic half();
    repeat (4) @(posedge clk);
  endtask : half
  task automatic start();
    cs_n <= 1'b0;
    half();
  endtask : start
  // sdi moves on the fall, sdo is taken at the end of the high half, just before the next fall
  task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      spc <= 1'b0;
      sdi <= tx[i];
      half();
      spc <= 1'b1;
      half();
      rx[i] = sdo;
    end
  endtask : xbyte
  // extra half bit lets the last write land before select rises
  task automatic stop();
    half();
    cs_n <= 1'b1;
    sdi  <= ~sdi;
    half();
  endtask : stop
endmodule : gcb_host_model
`default_nettype wire

// ===== verif/gyro_config_register_bank_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin fails++; \
  $display("wrong value at %0t: got %h want %h", $time, a, e); end end
module gyro_config_register_bank_bench;
  import gcb_pkg::*;
  logic                   clk = 1'b0, srst = 1'b1, last = 1'b0;
  wire logic              cs_n, spc, sdi, sdo;
  logic                   p1o, p1e, p2o, p2e, so, soe, busy;
  gcb_ro_data_type        ro = '0;
  gcb_events_type         ev = '0;
  gcb_cfg_type            cfg;
  logic [NUM_RW-1:0][7:0] regs;
  logic [7:0]             d, x, v, wv [NUM_RW];
  logic [31:0]            w;
  logic [7:0]             hv;
  logic [12:0]            hc;
  logic                   fr;
  int                     fails = 0, cmp_count = 0, fr_cnt = 0, n;
  always @(posedge clk) if (fr) fr_cnt++;
  always #5 clk = ~clk;
  // a released data line shows the inverse of its last bit
  assign sdo = soe ? so : ~last;
  always @(posedge clk) if (soe) last <= so;
  // ident value is arbitrary
  gcb_register_bank #(.DEVICE_IDENT(8'h3c), .BOOT_CYCLES(4)) dut (
    .clk(clk), .srst(srst), .spi_cs_n(cs_n), .spc(spc), .sdi(sdi), .ro_data(ro), .events(ev),
    .cfg(cfg), .ctrl_regs(regs), .boot_busy(busy), .filter_reset(fr), .sdo_out(so), .sdo_oe(soe),
    .event_pin_one_out(p1o), .event_pin_one_oe(p1e), .event_pin_two_out(p2o), .event_pin_two_oe(p2e));
  gcb_host_model h (.clk(clk), .sdo(sdo), .cs_n(cs_n), .spc(spc), .sdi(sdi));
  task automatic wr(input logic [6:0] a, input logic [7:0] b);
    h.start();
    h.xbyte({2'b00, a[5:0]}, x);
    h.xbyte(b, x);
    h.stop();
  endtask : wr
  task automatic rd(input logic [6:0] a);
    h.start();
    h.xbyte({2'b10, a[5:0]}, x);
    h.xbyte(8'h00, d);
    h.stop();
  endtask : rd
  // {out, oe}: open drain only ever pulls low
  function automatic logic [1:0] pin(input logic val, input logic od);
    return od ? {1'b0, ~val} : {val, 1'b1};
  endfunction : pin
  task automatic finish_test();
    $display("comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : finish_test
  initial begin
    void'($urandom(9647));
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    for (int i = 0; i < 60 && busy !== 1'b0; i++) @(posedge clk);
    if (busy !== 1'b0) begin
      fails++;
      finish_test();
    end
    for (int i = 0; i < NUM_RW; i++) begin
      rd(RW_ADDR[i]);
      `CHK(d, (i == S_RATE) ? 8'h07 : 8'h00)
    end
    for (int i = 0; i < NUM_RW; i++) begin
      v = 8'($urandom());
      if (i == S_HP) v[7:6] = 2'b00;
      if (i == S_PATH) v[REBOOT_BIT] = 1'b0;
      wv[i] = v;
      wr(RW_ADDR[i], v);
      rd(RW_ADDR[i]);
      `CHK(d, v)
      `CHK(regs[i], v)
    end
    for (int i = 0; i < 6; i++) begin
      v = 8'($urandom());
      if (i < 2) v[3:0] = {i[0], 3'b000};
      wr(A_RATE_AXIS_POWER_CTRL, v);
      `CHK(cfg.sample_rate_hz, 10'(100 << v[7:6]))
      `CHK(cfg.power_mode, !v[3] ? PWR_DOWN : (v[2:0] == 3'h0) ? PWR_SLEEP : PWR_NORMAL)
      `CHK(cfg.axis_enable, v[3] ? v[2:0] : 3'h0)
    end
    ro <= 80'({$urandom(), $urandom(), $urandom()});
    @(posedge clk);
    wr(A_TEMPERATURE_OUT, ~ro.temperature_out);
    rd(A_TEMPERATURE_OUT);
    `CHK(d, ro.temperature_out)
    rd(A_DEVICE_IDENT_CODE);
    `CHK(d, 8'h3c)
    rd(7'h05);
    `CHK(d, 8'h00)
    w = {ro.rate_y, ro.rate_x};
    h.start();
    h.xbyte({2'b11, A_RATE_X_LOW[5:0]}, x);
    for (int i = 0; i < 3; i++) begin
      h.xbyte(8'h00, d);
      `CHK(d, w[8*i +: 8])
    end
    h.stop();
    h.start();
    h.xbyte({2'b00, A_THRESHOLD_X_HIGH[5:0]}, x);
    h.xbyte(8'h5a, x);
    h.xbyte(8'ha5, x);
    h.stop();
    `CHK(regs[8], 8'ha5)
    `CHK(regs[9], wv[9])
    // last pass keeps the rate and writes an undefined cut-off code
    for (int i = 0; i < 6; i++) begin
      hv = {2'b00, 2'(i), (i == 5) ? 4'hc : 4'($urandom_range(9))};
      if (i < 5) begin
        v = 8'($urandom());
        wr(A_RATE_AXIS_POWER_CTRL, v);
        hc = HP_CHZ[{hv[3:0], v[7:6]}];
      end
      wr(A_HIGHPASS_CTRL, hv);
      n = fr_cnt;
      rd(A_FILTER_REFERENCE_VALUE);
      `CHK(fr_cnt != n, hv[5:4] == 2'b00)
      `CHK(cfg.hp_mode, hv[5:4])
      `CHK(cfg.hp_cutoff_chz, hc)
      `CHK(cfg.lowpass_dhz, LP_DHZ[v[7:4]])
    end
    for (int i = 0; i < 8; i++) begin
      v = 8'($urandom());
      v[R_P1_BOOT] = 1'b0;
      wr(A_PIN_EVENT_ROUTE_CTRL, v);
      ev <= 5'($urandom());
      repeat (3) @(posedge clk);
      `CHK({p1o, p1e}, pin((v[R_P1_EVENT] & ev.int_event) ^ v[R_P1_LOW], v[R_DRIVE_OD]))
      `CHK({p2o, p2e}, pin(|(v[3:0] & ev[3:0]), v[R_DRIVE_OD]))
    end
    finish_test();
  end
endmodule : gyro_config_register_bank_bench
`default_nettype wire
